/* verification/frg_flash_model.sv */
// behavioural flash device as seen from the controller pins
`timescale 1ns/1ns
`default_nettype none
module frg_flash_model #(
    parameter int BUSY_CYC = 200,
    parameter int ABORT_CYC = 6,
    parameter logic [7:0] CMD_RDARR = 8'hff,
    parameter logic [7:0] CMD_STAT = 8'h70,
    parameter logic [7:0] CMD_PROG = 8'h40,
    parameter logic [7:0] CMD_ERASE = 8'h20,
    parameter logic [7:0] CMD_CONF = 8'hd0
) (
    input wire logic pclk,
    input wire frg_pkg::frg_pins_s pins,
    input wire logic [7:0] dq_in,
    input wire logic vpp_ok,
    output logic [7:0] dq_out,
    output logic dq_en,
    output logic rb_n
);
    logic [7:0] mem [16];
    logic [7:0] setup_q;
    logic [7:0] dat_q;
    logic [3:0] pa_q;
    logic busy, stat_mode, abort, erase, ok_q, sup_err, prg_err, ers_err;
    int cnt;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {setup_q, busy, stat_mode, abort, erase, ok_q, sup_err, prg_err, ers_err} = '0;
        cnt = 0;
    end
    assign rb_n = !busy;
    assign dq_en = !pins.ce_n && !pins.oe_n && pins.reset_powerdown_n;
    assign dq_out = stat_mode ? {!busy, 1'b0, ers_err, prg_err, sup_err, 3'h0} : mem[pins.addr[3:0]];
    // writes need select, strobe, no reset
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.reset_powerdown_n && !busy) begin
            if (setup_q == CMD_PROG || (setup_q == CMD_ERASE && dq_in == CMD_CONF)) begin
                erase = (setup_q == CMD_ERASE);
                ok_q = vpp_ok;
                sup_err |= !vpp_ok;
                prg_err |= !vpp_ok && !erase;
                ers_err |= !vpp_ok && erase;
                cnt = vpp_ok ? BUSY_CYC : 2;
                busy = 1'b1;
                stat_mode = 1'b1;
                dat_q = dq_in;
                pa_q = pins.addr[3:0];
                setup_q = 8'h00;
            end else begin
                // decoder moves on host writes only
                setup_q = dq_in;
                if (dq_in == CMD_STAT) stat_mode = 1'b1;
                if (dq_in == CMD_RDARR) stat_mode = 1'b0;
            end
        end
    end
    // engine countdown; off the rising edge to avoid sampling races
    always @(negedge pclk) begin
        if (busy && cnt > 0) cnt--;
        else if (busy) begin
            busy = 1'b0;
            if (!abort && ok_q && erase) foreach (mem[i]) mem[i] = 8'hff;
            else if (!abort && ok_q) mem[pa_q] = dat_q;
            abort = 1'b0;
        end
    end
    // reset pin falls: clear status, abort engine
    always @(negedge pins.reset_powerdown_n) begin
        {sup_err, prg_err, ers_err, setup_q} = '0;
        if (busy) abort = 1'b1;
        if (busy) cnt = ABORT_CYC;
    end
    always @(posedge pins.reset_powerdown_n) stat_mode = 1'b0;
endmodule // frg_flash_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the flash guard controller
`timescale 1ns/1ns
`default_nettype none
`include "frg_consts.svh"
`define CHK(nm, ex, gt) begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
        n_fail++; \
        $display("wrong value %s expected %h seen %h", nm, ex, gt); \
    end \
end
module tb_top;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] ex; logic er;} frg_row_s;
    localparam logic [7:0] C_STAT = 8'h70;
    localparam logic [7:0] C_PROG = 8'h40;
    localparam logic [7:0] C_ERASE = 8'h20;
    localparam logic [7:0] C_CONF = 8'hd0;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic vpp_ok = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, irq, m_en, rb_n;
    logic [7:0] m_dq, dq_bus;
    frg_pkg::frg_pins_s pins;
    int n_fail = 0;
    int samples_checked = 0;
    frg_row_s rows [9] = '{
        '{1'b1, `FRG_OFF_ADDR, 32'hfff1_2345, 32'h0, 1'b0},
        '{1'b0, `FRG_OFF_ADDR, 32'h0, 32'h0001_2345, 1'b0},
        '{1'b1, `FRG_OFF_WDATA, 32'hffff_1234, 32'h0, 1'b0},
        '{1'b0, `FRG_OFF_WDATA, 32'h0, 32'h0000_1234, 1'b0},
        '{1'b1, `FRG_OFF_MASK, 32'hffff_ffff, 32'h0, 1'b0},
        '{1'b0, `FRG_OFF_MASK, 32'h0, 32'h0000_0003, 1'b0},
        '{1'b0, `FRG_OFF_RDATA, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1},
        '{1'b1, 8'h40, 32'h0, 32'h0, 1'b1}
    };
    // clock
    always #5 pclk = ~pclk;
    // dq wire: released lines show the inverse, never a stale value
    assign dq_bus = pins.dq_oe ? pins.dq_out : (m_en ? m_dq : ~m_dq);
    frg_ctrl #(.RESET_TO_OUTPUT_VALID_TIME_NS(500), .RESET_TO_WRITE_TIME_NS(500)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .flash_pins(pins), .flash_dq_in(dq_bus),
        .ready_busy_n_out(rb_n));
    frg_flash_model #(.CMD_STAT(C_STAT), .CMD_PROG(C_PROG), .CMD_ERASE(C_ERASE), .CMD_CONF(C_CONF)) u_flash (
        .pclk(pclk), .pins(pins), .dq_in(dq_bus), .vpp_ok(vpp_ok), .dq_out(m_dq), .dq_en(m_en), .rb_n(rb_n));
    always @(posedge pclk) begin
        if (presetn && pins.dq_oe && m_en) `CHK("dq contention", 1'b0, 1'b1)
    end
    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) n_fail++;
        if (i == 50) report_and_stop();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        `CHK("write response", 1'b0, e)
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, ex, r & m)
    endtask
    // poll one status bit, bounded
    task automatic wait_stat(input int b, input logic v);
        logic [31:0] r;
        logic e;
        int i;
        for (i = 0; i < 300; i++) begin
            apb(1'b0, `FRG_OFF_STAT, 32'h0, r, e);
            if (r[b] === v) break;
        end
        if (i == 300) n_fail++;
        if (i == 300) report_and_stop();
    endtask
    task automatic wait_busy();
        int i;
        for (i = 0; i < 200 && rb_n !== 1'b0; i++) @(posedge pclk);
        `CHK("busy seen", 1'b0, rb_n)
        // a busy level that never comes ends the run
        if (rb_n !== 1'b0) report_and_stop();
    endtask
    task automatic fop(input logic [1:0] op, input logic [19:0] a, input logic [15:0] wd);
        wr(`FRG_OFF_ADDR, {12'h000, a});
        wr(`FRG_OFF_WDATA, {16'h0000, wd});
        wr(`FRG_OFF_CTRL, {29'h0, op, 1'b1});
    endtask
    task automatic rd_flash(input logic [19:0] a, input logic [31:0] ex, input string nm);
        fop(`FRG_OP_READ, a, 16'h0000);
        wait_stat(0, 1'b0);
        rdc(`FRG_OFF_RDATA, 32'hff, ex, nm);
    endtask
    task automatic status_is(input logic [31:0] ex, input string nm);
        fop(`FRG_OP_CMD, 20'h00000, {8'h00, C_STAT});
        wait_stat(0, 1'b0);
        rd_flash(20'h00000, ex, nm);
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        int n;
        repeat (12) @(posedge pclk);
        `CHK("ce_n in reset", 1'b1, pins.ce_n)
        `CHK("we_n in reset", 1'b1, pins.we_n)
        `CHK("irq in reset", 1'b0, irq)
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d, r, e);
            `CHK("row error", rows[i].er, e)
            if (!rows[i].wr) `CHK("row data", rows[i].ex, r)
        end
        // program a byte, then read it back in array mode
        fop(`FRG_OP_SEQ, 20'h00005, {8'h3c, C_PROG});
        wait_busy();
        wait_stat(0, 1'b0);
        `CHK("irq done", 1'b1, irq)
        rdc(`FRG_OFF_IRQ, 32'hffff_ffff, 32'h1, "irq status");
        @(negedge pclk);
        `CHK("irq cleared", 1'b0, irq)
        rd_flash(20'h00005, 32'h3c, "array byte");
        // masked interrupt stays low until unmasked
        wr(`FRG_OFF_MASK, 32'h0);
        status_is(32'h80, "status idle");
        `CHK("masked irq", 1'b0, irq)
        wr(`FRG_OFF_MASK, 32'h3);
        @(negedge pclk);
        `CHK("unmasked irq", 1'b1, irq)
        rdc(`FRG_OFF_IRQ, 32'hffff_ffff, 32'h1, "irq status");
        // bad supply on program, then on erase; flags accumulate
        for (n = 0; n < 2; n++) begin
            vpp_ok <= 1'b0;
            fop(`FRG_OP_SEQ, 20'h00000, n ? {C_CONF, C_ERASE} : {8'h11, C_PROG});
            wait_stat(0, 1'b0);
            vpp_ok <= 1'b1;
            status_is(n ? 32'hb8 : 32'h98, "supply error");
        end
        // clear the done bits so the abort read sees the abort alone
        rdc(`FRG_OFF_IRQ, 32'hffff_ffff, 32'h1, "done bits only");
        // power-down while the engine runs
        fop(`FRG_OP_SEQ, 20'h00006, {8'h77, C_PROG});
        wait_busy();
        wr(`FRG_OFF_CTRL, 32'h8);
        wait_stat(2, 1'b1);
        `CHK("power-down pin", 1'b0, pins.reset_powerdown_n)
        rdc(`FRG_OFF_IRQ, 32'hffff_ffff, 32'h2, "abort irq");
        rdc(`FRG_OFF_STAT, 32'h9, 32'h8, "reissue flag");
        fop(`FRG_OP_READ, 20'h00005, 16'h0000);
        for (n = 0; n < 500 && pins.ce_n !== 1'b0; n++) @(posedge pclk);
        `CHK("wake gap", 1'b1, n >= 50)
        // a wake that never reaches the flash ends the run
        if (n == 500) begin
            n_fail++;
            report_and_stop();
        end
        wait_stat(0, 1'b0);
        rdc(`FRG_OFF_STAT, 32'h10, 32'h0, "recovery over");
        rdc(`FRG_OFF_RDATA, 32'hff, 32'h3c, "wake array mode");
        rd_flash(20'h00006, 32'h00, "aborted byte");
        status_is(32'h80, "status cleared");
        fop(`FRG_OP_SEQ, 20'h00006, {8'h77, C_PROG});
        wait_stat(0, 1'b0);
        rdc(`FRG_OFF_STAT, 32'h8, 32'h0, "reissue cleared");
        rd_flash(20'h00006, 32'h77, "reissued byte");
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire

/* verilog/frg_consts.svh */
// offsets, field positions, op and step codes and timing figures for the flash guard controller
`ifndef FRG_CONSTS_SVH
`define FRG_CONSTS_SVH
`define FRG_OFF_CTRL 8'h00
`define FRG_OFF_ADDR 8'h04
`define FRG_OFF_WDATA 8'h08
`define FRG_OFF_RDATA 8'h0c
`define FRG_OFF_STAT 8'h10
`define FRG_OFF_IRQ 8'h14
`define FRG_OFF_MASK 8'h18
`define FRG_CTRL_GO 0
`define FRG_CTRL_OP_LO 1
`define FRG_CTRL_OP_HI 2
`define FRG_CTRL_PD 3
`define FRG_OP_READ 2'h0
`define FRG_OP_CMD 2'h1
`define FRG_OP_SEQ 2'h2
`define FRG_STEP_FIRST 2'h0
`define FRG_STEP_SECOND 2'h1
`define FRG_STEP_RDARRAY 2'h2
`define FRG_STAT_BUSY 0
`define FRG_STAT_READY 1
`define FRG_STAT_PD 2
`define FRG_STAT_REISSUE 3
`define FRG_STAT_RECOV 4
`define FRG_IRQ_DONE 0
`define FRG_IRQ_ABORT 1
`define FRG_CLK_PERIOD_NS 10
`define FRG_MIN_RD_CYCLES 5
`define FRG_CNT_MAX 65535
`endif

/* verilog/frg_ctrl.sv */
// host-side flash controller: apb registers, strobe sequencer, power-down guard
`timescale 1ns/1ns
`default_nettype none
`include "frg_consts.svh"
module frg_ctrl #(
    parameter int RESET_TO_OUTPUT_VALID_TIME_NS = 1000,
    parameter int RESET_TO_WRITE_TIME_NS = 1000,
    parameter int WE_PULSE_NS = 100,
    parameter int WR_HOLD_NS = 20,
    parameter int RD_PULSE_NS = 150,
    parameter int BUSY_SETTLE_NS = 100,
    parameter logic [7:0] READ_ARRAY_CMD = 8'hff
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output frg_pkg::frg_pins_s flash_pins,
    input wire logic [frg_pkg::FRG_DATA_W-1:0] flash_dq_in,
    input wire logic ready_busy_n_out
);
    localparam int P = `FRG_CLK_PERIOD_NS;
    localparam int QV_CYC = (RESET_TO_OUTPUT_VALID_TIME_NS + P - 1) / P;
    localparam int WL_CYC = (RESET_TO_WRITE_TIME_NS + P - 1) / P;
    localparam int WE_CYC = (WE_PULSE_NS + P - 1) / P;
    localparam int HD_CYC = (WR_HOLD_NS + P - 1) / P;
    localparam int RD_CYC = (RD_PULSE_NS + P - 1) / P;
    localparam int ST_CYC = (BUSY_SETTLE_NS + P - 1) / P;
    localparam int REC_MAX = (QV_CYC > WL_CYC) ? QV_CYC : WL_CYC;
    localparam logic [15:0] QV_N = 16'(QV_CYC);
    localparam logic [15:0] WL_N = 16'(WL_CYC);
    localparam logic [15:0] WE_N = 16'((WE_CYC < 1) ? 1 : WE_CYC);
    localparam logic [15:0] HD_N = 16'((HD_CYC < 1) ? 1 : HD_CYC);
    localparam logic [15:0] RD_N = 16'(RD_CYC);
    localparam logic [15:0] ST_N = 16'((ST_CYC < 1) ? 1 : ST_CYC);
    localparam logic [15:0] REC_N = 16'(REC_MAX);

    // refuse timings that the 16-bit counters cannot hold, or a read too short for the synchroniser
    if (RD_CYC < `FRG_MIN_RD_CYCLES || REC_MAX > `FRG_CNT_MAX || RD_CYC > `FRG_CNT_MAX ||
        WE_CYC > `FRG_CNT_MAX || ST_CYC > `FRG_CNT_MAX || HD_CYC > `FRG_CNT_MAX) begin : g_bad_timing
        $error("frg_ctrl: timing parameters out of range");
    end

    frg_pkg::frg_regs_s r_q;
    frg_pkg::frg_regs_s r_d;
    logic [frg_pkg::FRG_DATA_W-1:0] dq_sync;
    logic rb_sync;
    logic [frg_pkg::FRG_IRQ_W-1:0] ev;
    logic [frg_pkg::FRG_IRQ_W-1:0] clr;
    logic fin;
    logic hit;
    logic acc;

    // pins from outside the clock domain
    frg_sync3 #(.W(frg_pkg::FRG_DATA_W + 1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({ready_busy_n_out, flash_dq_in}),
        .q({rb_sync, dq_sync})
    );

    // zero-wait slave; unmapped offsets answer with pslverr
    assign acc = psel && penable;
    assign hit = paddr inside {`FRG_OFF_CTRL, `FRG_OFF_ADDR, `FRG_OFF_WDATA, `FRG_OFF_RDATA,
                               `FRG_OFF_STAT, `FRG_OFF_IRQ, `FRG_OFF_MASK};
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = r_q.prdata;
    assign irq = |(r_q.irq_stat & r_q.irq_mask);
    assign flash_pins = r_q.pins;

    // next-state: bus side, recovery counter, sequencer
    always_comb begin
        r_d = r_q;
        ev = '0;
        fin = 1'b0;
        clr = (acc && !pwrite && paddr == `FRG_OFF_IRQ) ? r_q.irq_stat : '0;
        // read data is latched in the setup cycle so it comes from a flop
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `FRG_OFF_CTRL: r_d.prdata = 32'({r_q.pd_req, r_q.op, r_q.go_pend});
                `FRG_OFF_ADDR: r_d.prdata = 32'(r_q.addr);
                `FRG_OFF_WDATA: r_d.prdata = 32'(r_q.wdata);
                `FRG_OFF_RDATA: r_d.prdata = 32'(r_q.rdata);
                `FRG_OFF_STAT: r_d.prdata = 32'({r_q.pins.reset_powerdown_n && r_q.rec != REC_N, r_q.reissue,
                                                 !r_q.pins.reset_powerdown_n, rb_sync, r_q.go_pend});
                `FRG_OFF_IRQ: r_d.prdata = 32'(r_q.irq_stat);
                `FRG_OFF_MASK: r_d.prdata = 32'(r_q.irq_mask);
                default: r_d.prdata = 32'h0000_0000;
            endcase
        end
        if (acc && pwrite) begin
            unique case (paddr)
                `FRG_OFF_CTRL: begin
                    r_d.pd_req = pwdata[`FRG_CTRL_PD];
                    // a go while one is pending, or op code 3, is ignored
                    if (pwdata[`FRG_CTRL_GO] && !r_q.go_pend &&
                        pwdata[`FRG_CTRL_OP_HI:`FRG_CTRL_OP_LO] != 2'h3) begin
                        r_d.go_pend = 1'b1;
                        r_d.op = pwdata[`FRG_CTRL_OP_HI:`FRG_CTRL_OP_LO];
                    end
                end
                `FRG_OFF_ADDR: r_d.addr = pwdata[frg_pkg::FRG_ADDR_W-1:0];
                `FRG_OFF_WDATA: r_d.wdata = pwdata[2*frg_pkg::FRG_DATA_W-1:0];
                `FRG_OFF_MASK: r_d.irq_mask = pwdata[frg_pkg::FRG_IRQ_W-1:0];
                default: ;
            endcase
        end
        if (!r_q.pins.reset_powerdown_n) begin
            r_d.rec = '0;
        end else if (r_q.rec != REC_N) begin
            r_d.rec = r_q.rec + 16'h0001;
        end
        unique case (r_q.state)
            frg_pkg::frg_st_idle: begin
                if (r_q.pd_req) begin
                    r_d.pins.reset_powerdown_n = 1'b0;
                    r_d.state = frg_pkg::frg_st_pd;
                end else if (r_q.go_pend && r_q.op == `FRG_OP_READ && r_q.rec >= QV_N) begin
                    r_d.pins.addr = r_q.addr;
                    r_d.pins.ce_n = 1'b0;
                    r_d.pins.oe_n = 1'b0;
                    r_d.cnt = RD_N;
                    r_d.state = frg_pkg::frg_st_rd_pulse;
                end else if (r_q.go_pend && r_q.op != `FRG_OP_READ && r_q.rec >= WL_N) begin
                    r_d.pins.addr = r_q.addr;
                    r_d.pins.dq_out = r_q.wdata[frg_pkg::FRG_DATA_W-1:0];
                    r_d.pins.dq_oe = 1'b1;
                    r_d.pins.ce_n = 1'b0;
                    r_d.step = `FRG_STEP_FIRST;
                    r_d.state = frg_pkg::frg_st_wr_set;
                end
            end
            frg_pkg::frg_st_wr_set: begin
                r_d.pins.we_n = 1'b0;
                r_d.cnt = WE_N;
                r_d.state = frg_pkg::frg_st_wr_pulse;
            end
            frg_pkg::frg_st_wr_pulse: begin
                if (r_q.cnt == 16'h0001) begin
                    r_d.pins.we_n = 1'b1;
                    r_d.cnt = HD_N;
                    r_d.state = frg_pkg::frg_st_wr_hold;
                end else begin
                    r_d.cnt = r_q.cnt - 16'h0001;
                end
            end
            frg_pkg::frg_st_wr_hold: begin
                if (r_q.cnt == 16'h0001) begin
                    r_d.pins.ce_n = 1'b1;
                    r_d.pins.dq_oe = 1'b0;
                    if (r_q.op == `FRG_OP_SEQ && r_q.step == `FRG_STEP_FIRST) begin
                        r_d.step = `FRG_STEP_SECOND;
                        r_d.pins.dq_out = r_q.wdata[2*frg_pkg::FRG_DATA_W-1:frg_pkg::FRG_DATA_W];
                        r_d.pins.dq_oe = 1'b1;
                        r_d.pins.ce_n = 1'b0;
                        r_d.state = frg_pkg::frg_st_wr_set;
                    end else if (r_q.op == `FRG_OP_SEQ && r_q.step == `FRG_STEP_SECOND) begin
                        // settle lets ready/busy fall through the synchroniser
                        r_d.cnt = ST_N;
                        r_d.state = frg_pkg::frg_st_busy;
                    end else begin
                        fin = 1'b1;
                    end
                end else begin
                    r_d.cnt = r_q.cnt - 16'h0001;
                end
            end
            frg_pkg::frg_st_rd_pulse: begin
                if (r_q.cnt == 16'h0001) begin
                    r_d.rdata = dq_sync;
                    r_d.pins.ce_n = 1'b1;
                    r_d.pins.oe_n = 1'b1;
                    fin = 1'b1;
                end else begin
                    r_d.cnt = r_q.cnt - 16'h0001;
                end
            end
            frg_pkg::frg_st_busy: begin
                if (r_q.pd_req) begin
                    // abort by power-down needs a full reissue
                    r_d.pins.reset_powerdown_n = 1'b0;
                    r_d.reissue = 1'b1;
                    r_d.go_pend = 1'b0;
                    ev[`FRG_IRQ_ABORT] = 1'b1;
                    r_d.state = frg_pkg::frg_st_pd;
                end else if (r_q.cnt != 16'h0000) begin
                    r_d.cnt = r_q.cnt - 16'h0001;
                end else if (rb_sync) begin
                    r_d.reissue = 1'b0;
                    r_d.step = `FRG_STEP_RDARRAY;
                    r_d.pins.dq_out = READ_ARRAY_CMD;
                    r_d.pins.dq_oe = 1'b1;
                    r_d.pins.ce_n = 1'b0;
                    r_d.state = frg_pkg::frg_st_wr_set;
                end
            end
            frg_pkg::frg_st_pd: begin
                // flash wakes in array-read mode, so no command is due on exit
                if (!r_q.pd_req) begin
                    r_d.pins.reset_powerdown_n = 1'b1;
                    r_d.state = frg_pkg::frg_st_idle;
                end
            end
        endcase
        if (fin) begin
            r_d.go_pend = 1'b0;
            ev[`FRG_IRQ_DONE] = 1'b1;
            r_d.state = frg_pkg::frg_st_idle;
        end
        // a new event beats the read-clear in the same cycle
        r_d.irq_stat = (r_q.irq_stat & ~clr) | ev;
    end

    // the single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '0;
            r_q.state <= frg_pkg::frg_st_idle;
            r_q.pins.ce_n <= 1'b1;
            r_q.pins.oe_n <= 1'b1;
            r_q.pins.we_n <= 1'b1;
            r_q.pins.reset_powerdown_n <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    chk_we_under_ce: assert property (@(posedge pclk) disable iff (!presetn)
        !r_q.pins.we_n |-> !r_q.pins.ce_n && r_q.pins.oe_n && r_q.pins.dq_oe)
        else $error("write-enable low without select or with output-enable");
    chk_pd_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !r_q.pins.reset_powerdown_n |-> r_q.pins.ce_n && r_q.pins.we_n && r_q.pins.oe_n && !r_q.pins.dq_oe)
        else $error("strobes active during power-down");
    chk_write_recovery: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(r_q.pins.we_n) |-> r_q.rec >= WL_N)
        else $error("write before reset-to-write recovery");
    chk_read_recovery: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(r_q.pins.oe_n) |-> r_q.rec >= QV_N)
        else $error("read before reset-to-output recovery");
    chk_read_array_follow: assert property (@(posedge pclk) disable iff (!presetn)
        (r_q.state == frg_pkg::frg_st_busy && r_q.cnt == 16'h0000 && rb_sync && !r_q.pd_req) |=>
        r_q.state == frg_pkg::frg_st_wr_set ##1 !r_q.pins.we_n && r_q.pins.dq_out == READ_ARRAY_CMD)
        else $error("no read-array write after completion");
    chk_abort_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (r_q.state == frg_pkg::frg_st_busy && r_q.pd_req) |=>
        r_q.reissue && !r_q.pins.reset_powerdown_n && r_q.irq_stat[`FRG_IRQ_ABORT])
        else $error("abort not flagged for reissue");
    chk_two_writes: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r_q.state == frg_pkg::frg_st_busy) |-> r_q.op == `FRG_OP_SEQ && r_q.step == `FRG_STEP_SECOND)
        else $error("busy wait without the second write");
endmodule // frg_ctrl
`default_nettype wire

/* verilog/frg_pkg.sv */
// types shared by the flash guard controller
package frg_pkg;
    localparam int FRG_ADDR_W = 20;
    localparam int FRG_DATA_W = 8;
    localparam int FRG_IRQ_W = 2;

    typedef enum logic [2:0] {
        frg_st_idle, frg_st_wr_set, frg_st_wr_pulse, frg_st_wr_hold,
        frg_st_rd_pulse, frg_st_busy, frg_st_pd
    } frg_state_e;

    // everything the controller drives onto the flash
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic reset_powerdown_n;
        logic [FRG_ADDR_W-1:0] addr;
        logic [FRG_DATA_W-1:0] dq_out;
        logic dq_oe;
    } frg_pins_s;

    typedef struct packed {
        frg_state_e state;
        logic [15:0] cnt;
        logic [15:0] rec;
        logic [1:0] step;
        logic [1:0] op;
        logic go_pend;
        logic pd_req;
        logic [FRG_ADDR_W-1:0] addr;
        logic [2*FRG_DATA_W-1:0] wdata;
        logic [FRG_DATA_W-1:0] rdata;
        logic [FRG_IRQ_W-1:0] irq_stat;
        logic [FRG_IRQ_W-1:0] irq_mask;
        logic reissue;
        frg_pins_s pins;
        logic [31:0] prdata;
    } frg_regs_s;
endpackage

/* verilog/frg_sync3.sv */
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module frg_sync3 #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] q_q;

    // refuse a zero-width synchroniser at elaboration
    if (W < 1) begin : g_bad_w
        $error("frg_sync3: W must be at least 1");
    end

    // per bit: s1 feeds only s2, the agreement test looks at s2 and s3
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_q[i] <= 1'b0;
                s2_q[i] <= 1'b0;
                s3_q[i] <= 1'b0;
                q_q[i] <= 1'b0;
            end else begin
                s1_q[i] <= d[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    q_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign q = q_q;
endmodule // frg_sync3
`default_nettype wire
